/* shared/monitor_pkg.sv */
// Constants, field positions and carrier types of the current result and alert logic.
// Assumes a single importer; register offsets are the byte offsets seen by the serial front end.
package monitor_pkg;

    // Register offsets.
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    localparam logic [7:0] ADDR_CAL = 8'h05;
    localparam logic [7:0] ADDR_MASK = 8'h06;

    // Mask and enable field positions.
    localparam int SENSE_OVER_BIT = 15;
    localparam int SENSE_UNDER_BIT = 14;
    localparam int BUS_OVER_BIT = 13;
    localparam int BUS_UNDER_BIT = 12;
    localparam int POWER_OVER_BIT = 11;
    localparam int CONV_READY_EN_BIT = 10;
    localparam int ALERT_FLAG_BIT = 4;
    localparam int CONV_FLAG_BIT = 3;
    localparam int OVERFLOW_BIT = 2;
    localparam int POLARITY_BIT = 1;
    localparam int LATCH_BIT = 0;

    // Writable bits and reset values.
    localparam logic [15:0] CAL_WMASK = 16'h7fff;
    localparam logic [15:0] MASK_WMASK = 16'hfc03;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // One power step is this many current steps (decimal 25).
    localparam logic [4:0] POWER_STEP_RATIO = 5'h19;
    localparam int POWER_STEP_W = 20;

    // Limit comparison chosen by the enables.
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_SENSE_OVER = 3'b001,
        SEL_SENSE_UNDER = 3'b010,
        SEL_BUS_OVER = 3'b011,
        SEL_BUS_UNDER = 3'b100,
        SEL_POWER_OVER = 3'b101
    } limit_sel_type;

    // Register request from the serial front end.
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

    // Results of one finished conversion cycle.
    typedef struct packed {
        logic sense_meas;
        logic bus_meas;
        logic [15:0] sense;
        logic [15:0] bus;
        logic [15:0] power;
    } meas_type;

endpackage

/* verilog/current_alert.sv */
// Current result computation, calibration and mask registers, and open-drain alert drive.
// Assumes a serial-bus front end on lnk_clk_i and a converter on mclk_i that delivers averaged results.
`timescale 1ns/1ps
module current_alert
    import monitor_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic lnk_clk_i,
    input wire logic lnk_req_i,
    input wire reg_req_type lnk_req_data_i,
    output logic lnk_busy_o,
    output logic lnk_ack_o,
    output logic [15:0] lnk_rdata_o,
    input wire logic conv_done_i,
    input wire meas_type meas_i,
    input wire logic [15:0] alert_limit_i,
    input wire logic cfg_write_i,
    input wire logic cfg_powerdown_i,
    output logic [15:0] current_result_o,
    output logic [POWER_STEP_W-1:0] power_step_o,
    output logic alert_o,
    output logic alert_oe_n_o
);

    // Link domain state.
    logic lnk_rst1_q;
    logic lnk_rst2_q;
    logic req_tgl_q;
    reg_req_type hold_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;

    // Register clock domain state.
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic ack_tgl_q;
    logic [15:0] rdata_q;
    logic [15:0] cal_q;
    logic [15:0] mask_q;
    logic [15:0] current_q;
    logic stage_q;
    meas_type meas_q;
    logic ovf_stage_q;
    logic aff_q;
    logic conversion_ready_flag_q;
    logic ovf_q;
    logic alert_active_q;

    logic req_ev;
    logic mask_rd;
    logic signed [31:0] prod_w;
    logic prod_ovf;
    limit_sel_type sel;
    logic relevant;
    logic cond;
    logic [15:0] mask_view;

    // Synchronous reset brought into the link domain.
    always_ff @(posedge lnk_clk_i) begin
        lnk_rst1_q <= nrst_i;
        lnk_rst2_q <= lnk_rst1_q;
    end

    // Link side takes a request when idle and holds it until answered.
    always_ff @(posedge lnk_clk_i) begin
        if (!lnk_rst2_q) begin
            req_tgl_q <= 1'b0;
            hold_q <= '0;
            lnk_busy_o <= 1'b0;
        end else if (lnk_req_i && !lnk_busy_o) begin
            req_tgl_q <= ~req_tgl_q;
            hold_q <= lnk_req_data_i;
            lnk_busy_o <= 1'b1;
        end else if (ack_s2_q ^ ack_s3_q) begin
            lnk_busy_o <= 1'b0;
        end
    end

    // Answer toggle crosses back and becomes a one-cycle acknowledge.
    always_ff @(posedge lnk_clk_i) begin
        if (!lnk_rst2_q) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
            lnk_ack_o <= 1'b0;
            lnk_rdata_o <= REG_RESET;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            lnk_ack_o <= ack_s2_q ^ ack_s3_q;
            if (ack_s2_q ^ ack_s3_q) begin
                lnk_rdata_o <= rdata_q;
            end
        end
    end

    // Request toggle synchroniser.
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    assign req_ev = req_s2_q ^ req_s3_q;
    assign mask_rd = req_ev && !hold_q.wr && (hold_q.addr == ADDR_MASK);

    // Mask register as read: flags live in their own flip-flops.
    always_comb begin
        mask_view = mask_q & MASK_WMASK;
        mask_view[ALERT_FLAG_BIT] = aff_q;
        mask_view[CONV_FLAG_BIT] = conversion_ready_flag_q;
        mask_view[OVERFLOW_BIT] = ovf_q;
    end

    // Register access, read data captured before any read side effect.
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ack_tgl_q <= 1'b0;
            rdata_q <= REG_RESET;
            cal_q <= REG_RESET;
            mask_q <= REG_RESET;
        end else if (req_ev) begin
            ack_tgl_q <= ~ack_tgl_q;
            if (hold_q.wr) begin
                rdata_q <= REG_RESET;
                if (hold_q.addr == ADDR_CAL) begin
                    cal_q <= hold_q.wdata & CAL_WMASK;
                end else if (hold_q.addr == ADDR_MASK) begin
                    mask_q <= hold_q.wdata & MASK_WMASK;
                end
            end else if (hold_q.addr == ADDR_CURRENT) begin
                rdata_q <= current_q;
            end else if (hold_q.addr == ADDR_CAL) begin
                rdata_q <= cal_q;
            end else if (hold_q.addr == ADDR_MASK) begin
                rdata_q <= mask_view;
            end else begin
                rdata_q <= REG_RESET;
            end
        end
    end

    assign prod_w = $signed(meas_i.sense) * $signed({1'b0, cal_q[14:0]});
    // overflow when product leaves 16 bits
    assign prod_ovf = ($signed(prod_w[15:0]) != prod_w);

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            current_q <= REG_RESET;
            stage_q <= 1'b0;
            meas_q <= '0;
            ovf_stage_q <= 1'b0;
        end else begin
            stage_q <= conv_done_i;
            if (conv_done_i) begin
                current_q <= prod_w[15:0];
                meas_q <= meas_i;
                ovf_stage_q <= prod_ovf;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            power_step_o <= '0;
            current_result_o <= REG_RESET;
        end else begin
            power_step_o <= POWER_STEP_W'(cal_q[14:0] * POWER_STEP_RATIO);
            current_result_o <= current_q;
        end
    end

    always_comb begin
        if (mask_q[SENSE_OVER_BIT]) begin
            sel = SEL_SENSE_OVER;
        end else if (mask_q[SENSE_UNDER_BIT]) begin
            sel = SEL_SENSE_UNDER;
        end else if (mask_q[BUS_OVER_BIT]) begin
            sel = SEL_BUS_OVER;
        end else if (mask_q[BUS_UNDER_BIT]) begin
            sel = SEL_BUS_UNDER;
        end else if (mask_q[POWER_OVER_BIT]) begin
            sel = SEL_POWER_OVER;
        end else begin
            sel = SEL_NONE;
        end
    end

    always_comb begin
        relevant = 1'b0;
        cond = 1'b0;
        case (sel)
            SEL_SENSE_OVER: begin
                relevant = meas_q.sense_meas;
                cond = $signed(meas_q.sense) > $signed(alert_limit_i);
            end
            SEL_SENSE_UNDER: begin
                relevant = meas_q.sense_meas;
                cond = $signed(meas_q.sense) < $signed(alert_limit_i);
            end
            SEL_BUS_OVER: begin
                relevant = meas_q.bus_meas;
                cond = meas_q.bus > alert_limit_i;
            end
            SEL_BUS_UNDER: begin
                relevant = meas_q.bus_meas;
                cond = meas_q.bus < alert_limit_i;
            end
            SEL_POWER_OVER: begin
                relevant = meas_q.bus_meas;
                cond = meas_q.power > alert_limit_i;
            end
            default: begin
                relevant = 1'b1;
                cond = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            aff_q <= 1'b0;
        end else if (mask_q[LATCH_BIT]) begin
            if (stage_q && relevant && cond) begin
                aff_q <= 1'b1;
            end else if (mask_rd) begin
                aff_q <= 1'b0;
            end
        end else if (stage_q && relevant) begin
            aff_q <= cond;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            conversion_ready_flag_q <= 1'b0;
        end else if (stage_q) begin
            conversion_ready_flag_q <= 1'b1;
        end else if (mask_rd || (cfg_write_i && !cfg_powerdown_i)) begin
            conversion_ready_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ovf_q <= 1'b0;
        end else if (stage_q) begin
            ovf_q <= ovf_stage_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            alert_active_q <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_n_o <= 1'b1;
        end else begin
            alert_active_q <= aff_q || (mask_q[CONV_READY_EN_BIT] && conversion_ready_flag_q);
            alert_o <= 1'b0;
            alert_oe_n_o <= ~(alert_active_q ^ mask_q[POLARITY_BIT]);
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence conv_finished;
        conv_done_i ##1 stage_q;
    endsequence

    AST_CAL_TOP: assert property (cal_q[15] == 1'b0) else $error("calibration top bit set");
    AST_CURRENT_PRODUCT: assert property (conv_done_i |=> current_q == $past(prod_w[15:0]))
        else $error("current result is not the product");
    AST_SIGN_TRACK: assert property (conv_done_i && (prod_w < 0) && !prod_ovf |=> current_q[15])
        else $error("negative product lost its sign");
    AST_READY_SET: assert property (conv_finished |=> conversion_ready_flag_q) else $error("ready flag not set");
    AST_READY_CLR: assert property (mask_rd && !stage_q |=> !conversion_ready_flag_q)
        else $error("ready flag survived mask read");
    AST_LATCH_HOLD: assert property (aff_q && mask_q[LATCH_BIT] && !mask_rd && $stable(mask_q) |=> aff_q)
        else $error("latched alert flag dropped");
    AST_PRIORITY: assert property (mask_q[SENSE_OVER_BIT] |-> sel == SEL_SENSE_OVER)
        else $error("highest enable not selected");
    AST_OVERFLOW: assert property (conv_done_i && prod_ovf ##1 stage_q |=> ovf_q)
        else $error("overflow not flagged");
    AST_PIN_LEVEL: assert property (##1 alert_oe_n_o == !($past(alert_active_q) ^ $past(mask_q[POLARITY_BIT])))
        else $error("alert pin level wrong");
    AST_POWER_STEP: assert property ($stable(cal_q) [*2] |-> power_step_o == cal_q[14:0] * POWER_STEP_RATIO)
        else $error("power step not 25 current steps");

endmodule // current_alert

/* verification/host_model.sv */
// Host model that issues one register request at a time on the link port.
// Assumes the bench makes the link clock and calls access from one process.
`timescale 1ns/1ps
module host_model
    import monitor_pkg::*;
(
    input wire logic lnk_clk_i,
    input wire logic lnk_ack_i,
    input wire logic [15:0] lnk_rdata_i,
    output logic lnk_req_o,
    output reg_req_type lnk_req_data_o
);
    initial begin
        lnk_req_o = 1'b0;
        lnk_req_data_o = '0;
    end

    // Request is held until its answer, then the lines show the inverse.
    // A missing answer returns unknown data so that the caller counts a mismatch.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                          output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge lnk_clk_i);
        #1;
        lnk_req_o = 1'b1;
        lnk_req_data_o = '{wr, addr, wdata};
        do begin
            @(posedge lnk_clk_i);
            #1;
            n++;
        end while (lnk_ack_i !== 1'b1 && n < 40);
        rdata = (lnk_ack_i === 1'b1) ? lnk_rdata_i : 16'hxxxx;
        lnk_req_o = 1'b0;
        lnk_req_data_o = ~lnk_req_data_o;
    endtask
endmodule // host_model

/* verification/current_alert_tb_top.sv */
// Self-checking bench of the current result and alert logic.
// Assumes the host model drives the link port; conversions come from here.
`timescale 1ns/1ps
module current_alert_tb_top
    import monitor_pkg::*;
;
    logic mclk, nrst, lnk_clk, req, busy, ack, done, cfg_wr, cfg_pd, alert, oe_n;
    logic [15:0] rdata, cur, lim;
    logic [19:0] pstep;
    reg_req_type req_data;
    meas_type meas;
    int errors = 0;
    int tests_run = 0;

    current_alert current_alert_i (.mclk_i(mclk), .nrst_i(nrst), .lnk_clk_i(lnk_clk), .lnk_req_i(req),
        .lnk_req_data_i(req_data), .lnk_busy_o(busy), .lnk_ack_o(ack), .lnk_rdata_o(rdata),
        .conv_done_i(done), .meas_i(meas), .alert_limit_i(lim), .cfg_write_i(cfg_wr),
        .cfg_powerdown_i(cfg_pd), .current_result_o(cur), .power_step_o(pstep), .alert_o(alert),
        .alert_oe_n_o(oe_n));

    host_model host_model_i (.lnk_clk_i(lnk_clk), .lnk_ack_i(ack), .lnk_rdata_i(rdata),
        .lnk_req_o(req), .lnk_req_data_o(req_data));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        lnk_clk = 1'b0;
        #3.3;
        forever #6 lnk_clk = ~lnk_clk;
    end

    task automatic check(input string name, input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] r;
        host_model_i.access(1'b1, a, d, r);
        check("write answer", r, 16'h0000);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] r;
        host_model_i.access(1'b0, a, 16'h0000, r);
        check(name, {4'h0, r}, {4'h0, exp});
        check("link busy", busy, 1'b0);
    endtask

    task automatic settle();
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task automatic conv(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p);
        @(posedge mclk);
        #1;
        meas = '{1'b1, 1'b1, s, b, p};
        done = 1'b1;
        @(posedge mclk);
        #1;
        done = 1'b0;
        settle();
    endtask

    task automatic cfg(input logic pd);
        @(posedge mclk);
        #1;
        cfg_pd = pd;
        cfg_wr = 1'b1;
        @(posedge mclk);
        #1;
        cfg_wr = 1'b0;
        cfg_pd = 1'b0;
        settle();
    endtask

    task automatic t_reset();
        rd("cal", ADDR_CAL, REG_RESET);
        rd("mask", ADDR_MASK, REG_RESET);
        wr(ADDR_CURRENT, 16'hffff);
        rd("current", ADDR_CURRENT, REG_RESET);
        rd("unmapped", 8'h07, 16'h0000);
        check("pin idle", oe_n, 1'b1);
        $display("test reset done");
    endtask

    task automatic mul(input logic [15:0] c, input logic [15:0] s, input logic [15:0] e, input logic [15:0] m);
        wr(ADDR_CAL, c);
        conv(s, 16'h0100, 16'h0100);
        check("current out", cur, e);
        rd("current", ADDR_CURRENT, e);
        rd("flags", ADDR_MASK, m);
    endtask

    task automatic t_math();
        wr(ADDR_CAL, 16'hffff);
        rd("cal top", ADDR_CAL, 16'h7fff);
        check("power step", pstep, 20'h0_7fff * POWER_STEP_RATIO);
        mul(16'h7fff, 16'h0002, 16'hfffe, 16'h000c);
        mul(16'h0005, 16'hfffd, 16'hfff1, 16'h0008);
        mul(16'h0002, 16'h1234, 16'h2468, 16'h0008);
        check("power step", pstep, 20'h0_0002 * POWER_STEP_RATIO);
        $display("test math done");
    endtask

    task automatic t_limits();
        logic [15:0] sv [5] = '{16'h0200, 16'h0080, 16'h0100, 16'h0100, 16'h0100};
        logic [15:0] bv [5] = '{16'h0100, 16'h0100, 16'h0200, 16'h0080, 16'h0100};
        logic [15:0] pv [5] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0200};
        logic [15:0] en;
        wr(ADDR_CAL, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            en = 16'h8000 >> i;
            wr(ADDR_MASK, en);
            conv(sv[i], bv[i], pv[i]);
            check("limit pin", oe_n, 1'b0);
            rd("limit flag", ADDR_MASK, en | 16'h0018);
            conv(lim, lim, lim);
            check("clear pin", oe_n, 1'b1);
            rd("clear flag", ADDR_MASK, en | 16'h0008);
        end
        wr(ADDR_MASK, 16'h9000);
        conv(lim, 16'h0080, lim);
        check("prio pin", oe_n, 1'b1);
        rd("prio flag", ADDR_MASK, 16'h9008);
        $display("test limits done");
    endtask

    task automatic t_latch();
        wr(ADDR_MASK, 16'h8001);
        conv(16'h0200, lim, lim);
        conv(lim, lim, lim);
        check("latched pin", oe_n, 1'b0);
        rd("latched flag", ADDR_MASK, 16'h8019);
        settle();
        check("released pin", oe_n, 1'b1);
        rd("cleared flag", ADDR_MASK, 16'h8001);
        wr(ADDR_MASK, 16'h0002);
        settle();
        check("inverted idle", oe_n, 1'b0);
        check("pin data", alert, 1'b0);
        $display("test latch done");
    endtask

    task automatic t_ready();
        wr(ADDR_MASK, 16'h0400);
        conv(lim, lim, lim);
        check("ready pin", oe_n, 1'b0);
        cfg(1'b1);
        check("powerdown keeps", oe_n, 1'b0);
        cfg(1'b0);
        check("cfg clears", oe_n, 1'b1);
        conv(lim, lim, lim);
        rd("ready flag", ADDR_MASK, 16'h0408);
        settle();
        check("read clears", oe_n, 1'b1);
        $display("test ready done");
    endtask

    initial begin
        #100us;
        errors++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        nrst = 1'b0;
        done = 1'b0;
        cfg_wr = 1'b0;
        cfg_pd = 1'b0;
        meas = '0;
        lim = 16'h0100;
        repeat (10) @(posedge mclk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge lnk_clk);
        t_reset();
        t_math();
        t_limits();
        t_latch();
        t_ready();
        test_done();
    end
endmodule // current_alert_tb_top
